// file: hw/elr_pkg.sv
// Package for the event link router: register map, field layout, encodings
//
// Notes on behaviour
// - Select value zero disconnects the destination from all events.
// - Select one to BD links the event source of that number.
// - 82 event types reach destinations with no processor in the path.
// - Setting registers exist only for the listed destination indices.
// - Timer reaction to an incoming event is chosen by configuration.
// - Only port B and port E take part in event linking.
// - Single-port mode ties one chosen port bit to the event link.
// - Port-group mode makes chosen bits of a port act as one link.
// - Option A bits 1:0 select the multi pulse timer channel 0 action.
// - Option register D bits 3:2 select byte timer 1 action.
// - Option register D bits 7:6 select byte timer 3 action.
// - Software can place the router in module stop, halting all routing.
// - General pulse timer gives compare, overflow, underflow events.
// - General pulse timer 0-3 starts, restarts or captures on an event.
// - Byte timers 0-3 start, count events or restart on a routed event.
// - Byte timers 0-3 offer compare A, compare B and overflow events.

package elr_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int          SRC_W         = 190;
  localparam int          DEST_W        = 46;
  localparam int          NUM_EVT_TYPES = 82;
  localparam logic [7:0]  SEL_OFF       = 8'h00;
  localparam logic [7:0]  SEL_MAX       = 8'hBD;
  localparam logic [45:0] DEST_PRESENT  = 46'h207A_1FFD_BC99;

  // ---------------------------------------------------------------
  // Port event sources and destinations
  // ---------------------------------------------------------------
  localparam logic [7:0] SRC_PORT_B  = 8'hB8;
  localparam logic [7:0] SRC_PORT_E  = 8'hB9;
  localparam int         DEST_PORT_B = 36;
  localparam int         DEST_PORT_E = 37;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_SETTING  = 12'h000;
  localparam logic [11:0] OFS_SET_END  = 12'h0B8;
  localparam logic [11:0] OFS_OPT_A    = 12'h0C0;
  localparam logic [11:0] OFS_OPT_D    = 12'h0CC;
  localparam logic [11:0] OFS_OPT_GPT  = 12'h0D0;
  localparam logic [11:0] OFS_PORT_B   = 12'h0E0;
  localparam logic [11:0] OFS_PORT_E   = 12'h0E4;
  localparam logic [11:0] OFS_CTRL     = 12'h0F0;
  localparam logic [11:0] OFS_STATUS   = 12'h0F4;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         OPT_A_MPT0_LSB = 0;
  localparam int         OPT_D_BT1_LSB  = 2;
  localparam int         OPT_D_BT3_LSB  = 6;
  localparam int         PCFG_GROUP_BIT = 0;
  localparam int         PCFG_BSEL_LSB  = 4;
  localparam int         PCFG_MASK_LSB  = 8;
  localparam int         CTRL_STOP_BIT  = 0;
  localparam int         STAT_CNT_LSB   = 8;
  localparam logic [7:0] RST_BYTE       = 8'h00;

  // ---------------------------------------------------------------
  // Action encodings seen by the timers
  // ---------------------------------------------------------------
  localparam logic [1:0] BT_ACT_START   = 2'h0;
  localparam logic [1:0] BT_ACT_COUNT   = 2'h1;
  localparam logic [1:0] BT_ACT_RESTART = 2'h2;
  localparam logic [1:0] GPT_ACT_START  = 2'h0;
  localparam logic [1:0] GPT_ACT_RESTRT = 2'h1;
  localparam logic [1:0] GPT_ACT_CAPT   = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mask;
    logic [2:0] bitsel;
    logic       group;
  } elr_port_cfg_t;

  typedef struct packed {
    logic [7:0] gpt;
    logic [7:0] byte_tmr;
    logic [1:0] mpt0;
  } elr_timer_act_t;

endpackage

// file: hw/elr_event_link_router.sv
// Event link router: APB register file, source select muxes, port events
`timescale 1ns/1ns
`default_nettype none

module elr_event_link_router
  import elr_pkg::*;
(
  // Clock and reset
  input  wire  logic                 sys_clk_i,
  input  wire  logic                 rst_i,
  // APB slave
  input  wire  logic                 psel_i,
  input  wire  logic                 penable_i,
  input  wire  logic                 pwrite_i,
  input  wire  logic [11:0]          paddr_i,
  input  wire  logic [31:0]          pwdata_i,
  input  wire  logic [3:0]           pstrb_i,
  output logic       [31:0]          prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Event sources, bit n is source number n
  input  wire  logic [SRC_W-1:0]     src_evt_i,
  // Port pins taking part in linking
  input  wire  logic [7:0]           port_b_pin_i,
  input  wire  logic [7:0]           port_e_pin_i,
  // Destination events and port event drive
  output logic       [DEST_W-1:0]    dest_evt_o,
  output logic       [7:0]           port_b_evt_o,
  output logic       [7:0]           port_e_evt_o,
  // Timer actions and state
  output elr_timer_act_t             timer_act_o,
  output logic                       stopped_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Select bytes exist for every index; absent ones stay at reset
  // because the decoder never reaches them
  // Module stop gates routing only; registers stay reachable
  logic [7:0]        sel_q [DEST_W];
  logic [7:0]        sel_d [DEST_W];
  elr_timer_act_t    act_q;
  elr_timer_act_t    act_d;
  elr_port_cfg_t     pb_cfg_q;
  elr_port_cfg_t     pb_cfg_d;
  elr_port_cfg_t     pe_cfg_q;
  elr_port_cfg_t     pe_cfg_d;
  logic              stop_q;
  logic              stop_d;
  logic [7:0]        cnt_q;
  logic [7:0]        cnt_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic [SRC_W-1:0]  src_prev_q;
  logic [SRC_W-1:0]  src_now;
  logic [SRC_W-1:0]  src_edge;
  logic [DEST_W-1:0] dest_q;
  logic [DEST_W-1:0] dest_d;
  logic [7:0]        pb_out_q;
  logic [7:0]        pb_out_d;
  logic [7:0]        pe_out_q;
  logic [7:0]        pe_out_d;

  // ---------------------------------------------------------------
  // Address decode and read data
  // ---------------------------------------------------------------
  // Setting word n sits at four times n; unaligned, absent or unknown
  // addresses answer with an error and read as zero
  logic        hit;
  logic        set_hit;
  logic [5:0]  set_idx;
  logic [31:0] rd_val;
  logic        access;
  logic        wr_now;

  assign access = psel_i && penable_i;
  assign wr_now = access && pready_q && pwrite_i && hit;

  always_comb
  begin
    set_idx = paddr_i[7:2];
    set_hit = (paddr_i[1:0] == 2'b00) && (paddr_i < OFS_SET_END)
              && DEST_PRESENT[set_idx];
    hit     = set_hit;
    rd_val  = 32'h0000_0000;
    if (set_hit)
    begin
      rd_val[7:0] = sel_q[set_idx];
    end
    else
    begin
      hit = 1'b1;
      case (paddr_i)
        OFS_OPT_A:   rd_val[1:0]  = act_q.mpt0;
        OFS_OPT_D:   rd_val[7:0]  = act_q.byte_tmr;
        OFS_OPT_GPT: rd_val[7:0]  = act_q.gpt;
        OFS_PORT_B:  rd_val[15:0] = {pb_cfg_q.mask, 1'b0, pb_cfg_q.bitsel,
                                     3'b000, pb_cfg_q.group};
        OFS_PORT_E:  rd_val[15:0] = {pe_cfg_q.mask, 1'b0, pe_cfg_q.bitsel,
                                     3'b000, pe_cfg_q.group};
        OFS_CTRL:    rd_val[CTRL_STOP_BIT] = stop_q;
        OFS_STATUS:
        begin
          rd_val[CTRL_STOP_BIT]             = stop_q;
          rd_val[STAT_CNT_LSB +: 8]         = cnt_q;
        end
        default:     hit = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // APB handshake: one wait state, answer registered
  // ---------------------------------------------------------------
  // Ready rises in the second access cycle for one cycle only;
  // read data holds until the next answer
  always_comb
  begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (access && !pready_q)
    begin
      pready_d  = 1'b1;
      pslverr_d = !hit;
      prdata_d  = pwrite_i ? 32'h0000_0000 : rd_val;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Writes land at the edge where ready is seen high; lanes with a
  // low strobe keep their old contents
  // The status word is read only and ignores writes
  always_comb
  begin
    sel_d    = sel_q;
    act_d    = act_q;
    pb_cfg_d = pb_cfg_q;
    pe_cfg_d = pe_cfg_q;
    stop_d   = stop_q;
    if (wr_now && set_hit && pstrb_i[0])
    begin
      sel_d[set_idx] = pwdata_i[7:0];
    end
    else if (wr_now)
    begin
      case (paddr_i)
        OFS_OPT_A:
          if (pstrb_i[0])
            act_d.mpt0 = pwdata_i[OPT_A_MPT0_LSB +: 2];
        OFS_OPT_D:
          if (pstrb_i[0])
          begin
            act_d.byte_tmr = pwdata_i[7:0];
            act_d.byte_tmr[OPT_D_BT1_LSB +: 2] =
              pwdata_i[OPT_D_BT1_LSB +: 2];
            act_d.byte_tmr[OPT_D_BT3_LSB +: 2] =
              pwdata_i[OPT_D_BT3_LSB +: 2];
          end
        OFS_OPT_GPT:
          if (pstrb_i[0])
            act_d.gpt = pwdata_i[7:0];
        OFS_PORT_B:
        begin
          if (pstrb_i[0])
          begin
            pb_cfg_d.group  = pwdata_i[PCFG_GROUP_BIT];
            pb_cfg_d.bitsel = pwdata_i[PCFG_BSEL_LSB +: 3];
          end
          if (pstrb_i[1])
            pb_cfg_d.mask = pwdata_i[PCFG_MASK_LSB +: 8];
        end
        OFS_PORT_E:
        begin
          if (pstrb_i[0])
          begin
            pe_cfg_d.group  = pwdata_i[PCFG_GROUP_BIT];
            pe_cfg_d.bitsel = pwdata_i[PCFG_BSEL_LSB +: 3];
          end
          if (pstrb_i[1])
            pe_cfg_d.mask = pwdata_i[PCFG_MASK_LSB +: 8];
        end
        OFS_CTRL:
          if (pstrb_i[0])
            stop_d = pwdata_i[CTRL_STOP_BIT];
        default:
        begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Routing
  // ---------------------------------------------------------------
  // Timer compare, overflow and underflow outputs arrive as numbered
  // sources; the router treats them like any other source
  logic pb_lvl;
  logic pe_lvl;

  always_comb
  begin
    // Single bit or any masked bit of the group raises the port event
    pb_lvl = pb_cfg_q.group ? |(port_b_pin_i & pb_cfg_q.mask)
                            : port_b_pin_i[pb_cfg_q.bitsel];
    pe_lvl = pe_cfg_q.group ? |(port_e_pin_i & pe_cfg_q.mask)
                            : port_e_pin_i[pe_cfg_q.bitsel];
    src_now             = src_evt_i;
    src_now[0]          = 1'b0;
    src_now[SRC_PORT_B] = pb_lvl;
    src_now[SRC_PORT_E] = pe_lvl;
    src_edge            = src_now & ~src_prev_q;
  end

  always_comb
  begin
    cnt_d = cnt_q;
    for (int d = 0; d < DEST_W; d++)
    begin
      // Out-of-range select codes are treated as disconnected
      dest_d[d] = DEST_PRESENT[d] && !stop_q
                  && (sel_q[d] != SEL_OFF)
                  && (sel_q[d] <= SEL_MAX)
                  && src_edge[sel_q[d]];
    end
    if (|dest_d)
      cnt_d = cnt_q + 8'h01;
    // Port destinations drive the single bit or the whole group mask
    pb_out_d = 8'h00;
    pe_out_d = 8'h00;
    if (dest_d[DEST_PORT_B])
      pb_out_d = pb_cfg_q.group ? pb_cfg_q.mask
                                : 8'h01 << pb_cfg_q.bitsel;
    if (dest_d[DEST_PORT_E])
      pe_out_d = pe_cfg_q.group ? pe_cfg_q.mask
                                : 8'h01 << pe_cfg_q.bitsel;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Edge memory starts low: a source already high at release gives
  // one event in the first cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int d = 0; d < DEST_W; d++)
        sel_q[d] <= RST_BYTE;
      act_q      <= '0;
      pb_cfg_q   <= '0;
      pe_cfg_q   <= '0;
      stop_q     <= 1'b0;
      cnt_q      <= 8'h00;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      prdata_q   <= 32'h0000_0000;
      src_prev_q <= '0;
      dest_q     <= '0;
      pb_out_q   <= 8'h00;
      pe_out_q   <= 8'h00;
    end
    else
    begin
      sel_q      <= sel_d;
      act_q      <= act_d;
      pb_cfg_q   <= pb_cfg_d;
      pe_cfg_q   <= pe_cfg_d;
      stop_q     <= stop_d;
      cnt_q      <= cnt_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      prdata_q   <= prdata_d;
      src_prev_q <= src_now;
      dest_q     <= dest_d;
      pb_out_q   <= pb_out_d;
      pe_out_q   <= pe_out_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a plain copy of a flop, no logic after it
  assign prdata_o     = prdata_q;
  assign pready_o     = pready_q;
  assign pslverr_o    = pslverr_q;
  assign dest_evt_o   = dest_q;
  assign port_b_evt_o = pb_out_q;
  assign port_e_evt_o = pe_out_q;
  assign timer_act_o  = act_q;
  assign stopped_o    = stop_q;

endmodule

`default_nettype wire

// file: tb/elr_router_asserts.sv
// Port checker for the event link router
`timescale 1ns/1ns
`default_nettype none

module elr_router_asserts
  import elr_pkg::*;
(
  // Clock, reset and bus answer
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pready_o,
  input  wire logic                 pslverr_o,
  // Routed events and state
  input  wire logic [DEST_W-1:0]    dest_evt_o,
  input  wire logic [7:0]           port_b_evt_o,
  input  wire logic [7:0]           port_e_evt_o,
  input  wire elr_timer_act_t       timer_act_o,
  input  wire logic                 stopped_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  AST_APB_ONE_WAIT: assert property
    (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
    else $error("ready not in second access cycle");
  AST_READY_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready_o |-> s_access)
    else $error("ready outside access phase");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  AST_EVT_SINGLE: assert property
    ((dest_evt_o & $past(dest_evt_o)) == '0)
    else $error("destination pulse longer than one cycle");
  AST_ABSENT_QUIET: assert property
    ((dest_evt_o & ~DEST_PRESENT) == '0)
    else $error("absent destination pulsed");
  AST_STOP_GATES: assert property
    (stopped_o && $past(stopped_o) |-> dest_evt_o == '0)
    else $error("event routed in module stop");
  AST_RESET_CLEAR: assert property
    ($fell(rst_i) |-> timer_act_o == '0 && !stopped_o)
    else $error("state not clear after reset");
  AST_PORT_B_FOLLOWS: assert property
    (port_b_evt_o != '0 |-> dest_evt_o[DEST_PORT_B])
    else $error("port b drive without its destination");
  AST_PORT_E_FOLLOWS: assert property
    (port_e_evt_o != '0 |-> dest_evt_o[DEST_PORT_E])
    else $error("port e drive without its destination");
endmodule

bind elr_event_link_router elr_router_asserts i_elr_router_asserts (
  .sys_clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
  .dest_evt_o, .port_b_evt_o, .port_e_evt_o, .timer_act_o, .stopped_o);

`default_nettype wire

// file: tb/elr_evt_periph.sv
// Model of the peripherals that raise numbered events
`timescale 1ns/1ns
`default_nettype none

module elr_evt_periph
  import elr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Request to raise one source
  input  wire logic             fire_i,
  input  wire logic [7:0]       num_i,
  // Event levels
  output logic      [SRC_W-1:0] src_evt_o
);
  logic [7:0] num_q;
  logic [7:0] num_d;
  logic [1:0] left_q;
  logic [1:0] left_d;

  // Level held three cycles: a held source must still give one event
  always_comb
  begin
    num_d = num_q;
    left_d = left_q;
    if (fire_i && left_q == 2'h0)
    begin
      num_d = num_i;
      left_d = 2'h3;
    end
    else if (left_q != 2'h0)
      left_d = left_q - 2'h1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      num_q <= 8'h00;
      left_q <= 2'h0;
    end
    else
    begin
      num_q <= num_d;
      left_q <= left_d;
    end

  // One numbered source at a time
  assign src_evt_o = (left_q != 2'h0) ? (SRC_W'(1) << num_q) : '0;
endmodule

`default_nettype wire

// file: tb/test_event_link_router.sv
// Self-checking bench for the event link router
`timescale 1ns/1ns
`default_nettype none

module test_event_link_router
  import elr_pkg::*;
;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             psel = 1'b0;
  logic             pen = 1'b0;
  logic             pwr = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0000_0000;
  logic [3:0]       pstrb = 4'hF;
  logic [7:0]       pinb = 8'h00;
  logic [7:0]       pine = 8'h00;
  logic             fire = 1'b0;
  logic [7:0]       fnum = 8'h00;
  logic [31:0]      prdata;
  logic [31:0]      rdat;
  logic             pready;
  logic             perr;
  logic             rerr;
  logic [SRC_W-1:0] src;
  logic [45:0]      dest;
  logic [7:0]       pbe;
  logic [7:0]       pee;
  logic [7:0]       pb_s;
  logic [7:0]       pe_s;
  elr_timer_act_t   act;
  logic             stopped;
  int               mismatches = 0;
  int               checked = 0;

  always #20 clk = ~clk;

  elr_evt_periph i_elr_evt_periph (.clk_i(clk), .rst_i(rst),
    .fire_i(fire), .num_i(fnum), .src_evt_o(src));

  elr_event_link_router i_elr_event_link_router (.sys_clk_i(clk),
    .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .src_evt_i(src), .port_b_pin_i(pinb), .port_e_pin_i(pine),
    .dest_evt_o(dest), .port_b_evt_o(pbe), .port_e_evt_o(pee),
    .timer_act_o(act), .stopped_o(stopped));

  task wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 16)
    begin
      mismatches++;
      $display("mismatch at %0t: no ready", $time);
      wrap_up();
    end
    else
    begin
      // Answer taken at the edge that sees ready high, then released
      rdat = prdata;
      rerr = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      #1;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(rerr, 1'b0);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
    chk(rerr, 1'b0);
  endtask

  // Expected pulse one cycle after the source level, then silence
  task pulse_chk(input logic [45:0] e);
    @(posedge clk);
    #1;
    chk(dest, e);
    pb_s = pbe;
    pe_s = pee;
    @(posedge clk);
    #1;
    chk(dest, 46'h0);
  endtask

  task ev(input logic [7:0] n, input logic [45:0] e);
    @(posedge clk);
    fire <= 1'b1;
    fnum <= n;
    @(posedge clk);
    fire <= 1'b0;
    pulse_chk(e);
    @(posedge clk);
  endtask

  task pin(input logic [7:0] b, input logic [7:0] p, input logic [45:0] e);
    @(posedge clk);
    pinb <= b;
    pine <= p;
    pulse_chk(e);
    @(posedge clk);
    pinb <= 8'h00;
    pine <= 8'h00;
  endtask

  task t_reset;
    logic [11:0] a [6] = '{12'h000, 12'h0B4, 12'h0C0,
                           12'h0CC, 12'h0D0, 12'h0F0};
    foreach (a[i])
      rd(a[i], 32'h0000_0000);
    $display("test reset done");
  endtask

  // Selects stay within 00..BD
  task t_route;
    int         d [5] = '{0, 45, 3, 0, 45};
    logic [7:0] s [5] = '{8'h01, 8'hBD, 8'h52, 8'h00, 8'h00};
    logic [7:0] f [5] = '{8'h01, 8'hBD, 8'h52, 8'h01, 8'hBD};
    logic [45:0] x;
    for (int i = 0; i < 5; i++)
    begin
      wr(12'(4 * d[i]), {24'h00_0000, s[i]});
      rd(12'(4 * d[i]), {24'h00_0000, s[i]});
      x = (s[i] != 8'h00) ? 46'(1) << d[i] : 46'h0;
      ev(f[i], x);
    end
    apb(1'b1, 12'h004, 32'h0000_0001);
    chk(rerr, 1'b1);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({rerr, rdat}, {1'b1, 32'h0000_0000});
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk(rerr, 1'b1);
    $display("test route done");
  endtask

  task t_opts;
    logic [7:0] v;
    wr(12'h0C0, 32'h0000_0003);
    chk(act.mpt0, 2'h3);
    v = {BT_ACT_RESTART, BT_ACT_START, BT_ACT_COUNT, BT_ACT_START};
    wr(12'h0CC, {24'h00_0000, v});
    chk(act.byte_tmr[3:2], BT_ACT_COUNT);
    chk(act.byte_tmr[7:6], BT_ACT_RESTART);
    @(posedge clk);
    pstrb <= 4'h0;
    wr(12'h0CC, 32'h0000_00FF);
    @(posedge clk);
    pstrb <= 4'hF;
    rd(12'h0CC, {24'h00_0000, v});
    v = {GPT_ACT_CAPT, GPT_ACT_RESTRT, GPT_ACT_START, GPT_ACT_CAPT};
    wr(12'h0D0, {24'h00_0000, v});
    chk(act.gpt, v);
    $display("test options done");
  endtask

  task t_stop;
    wr(12'h000, 32'h0000_0001);
    wr(12'h0F0, 32'h0000_0001);
    chk(stopped, 1'b1);
    ev(8'h01, 46'h0);
    wr(12'h0F0, 32'h0000_0000);
    ev(8'h01, 46'h1);
    wr(12'h000, 32'h0000_0000);
    $display("test stop done");
  endtask

  task t_port;
    wr(12'h0E0, 32'h0000_0050);
    rd(12'h0E0, 32'h0000_0050);
    wr(12'(4 * DEST_PORT_B), 32'h0000_0001);
    ev(8'h01, 46'(1) << DEST_PORT_B);
    chk(pb_s, 8'h20);
    wr(12'h00C, {24'h00_0000, SRC_PORT_B});
    pin(8'h20, 8'h00, 46'h8);
    wr(12'h0E4, 32'h0000_8101);
    rd(12'h0E4, 32'h0000_8101);
    wr(12'(4 * DEST_PORT_E), 32'h0000_0001);
    ev(8'h01, 46'(3) << DEST_PORT_B);
    chk(pe_s, 8'h81);
    wr(12'h010, {24'h00_0000, SRC_PORT_E});
    pin(8'h00, 8'h80, 46'h10);
    pin(8'h00, 8'h02, 46'h0);
    $display("test port done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_opts();
    t_stop();
    t_port();
    wrap_up();
  end
endmodule

`default_nettype wire
